//--- src/command_source_arbiter.sv
// routes drive input functions from terminals or network per source settings
//
// Operation
// [RQ1] Routed functions take network at operation source 0, terminals at 1.
// [RQ2] Emergency drive command is terminal OR network under any setting.
// [RQ3] Sequence start takes either input at setting 1, terminal only at 2.
// [RQ4] A combined normally-open function is on when either input is on.
// [RQ5] A combined normally-closed function is on only when both are on.
// [RQ6] Source settings change while running only if write selection is 2.
// [RQ7] A source change made while running applies once the drive stops.
// [RQ8] Writing 67 into a terminal's function code assigns switchover to it.
// [RQ9] Switchover unassigned or on: network mode sources follow settings.
// [RQ10] Switchover off: operation and speed commands come from terminals.
// [RQ11] A switchover change while running is applied only once stopped.
// [RQ12] While switchover is off, network reset requests are rejected.
// [RQ13] Terminal and network inputs are synchronised before any merging.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "cmd_src_regs.svh"
module command_source_arbiter
    import cmd_src_pkg::*;
#(
    parameter int TERM_COUNT  = `ASSIGN_COUNT,
    parameter int SPEED_WIDTH = 16
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    // register port
    input  wire logic [7:0]             reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [31:0]            reg_rdata,
    // drive state
    input  wire logic                   drive_running,
    // control terminals
    input  wire func_bits_type          term_func,
    input  wire logic [TERM_COUNT-1:0]  term_pins,
    input  wire logic [SPEED_WIDTH-1:0] term_speed,
    // network interface
    input  wire func_bits_type          net_func,
    input  wire logic                   net_reset_req,
    input  wire logic [SPEED_WIDTH-1:0] net_speed,
    // to the drive
    output func_bits_type               eff_func,
    output logic                        op_from_net,
    output logic                        spd_from_net,
    output logic      [SPEED_WIDTH-1:0] speed_ref,
    output logic                        drive_reset_req
);

    localparam int FW   = $bits(func_bits_type);
    localparam int SYNW = 2 * FW + TERM_COUNT + 1;

    // synchronised inputs
    logic [SYNW-1:0]       sync_raw;
    logic [SYNW-1:0]       sync_vec;
    func_bits_type         t_s;
    func_bits_type         n_s;
    logic [TERM_COUNT-1:0] pins_s;
    logic                  net_rst_s;

    assign sync_raw = {term_func, net_func, term_pins, net_reset_req};

    sync_bank #(
        .WIDTH (SYNW)
    ) sync_bank_inst (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in (sync_raw),
        .sync_out (sync_vec)
    ); // [RQ13]

    assign t_s       = sync_vec[SYNW-1 -: FW];
    assign n_s       = sync_vec[SYNW-FW-1 -: FW];
    assign pins_s    = sync_vec[TERM_COUNT:1];
    assign net_rst_s = sync_vec[0];

    // register state
    src_sel_type src_req_q;
    src_sel_type src_act_q;
    logic [1:0]  pws_q;
    logic [1:0]  seq_sel_q;
    logic        net_mode_q;
    logic [7:0]  assign_q [TERM_COUNT];
    logic        sw_act_q;
    logic        net_rst_prev_q;
    logic        reset_req_q;
    func_bits_type eff_q;
    logic        op_net_q;
    logic        spd_net_q;
    logic [SPEED_WIDTH-1:0] speed_q;
    logic [31:0] rdata_q;

    // address decode
    wire       hit_cfg    = (reg_addr == `ADDR_CFG);
    wire       hit_status = (reg_addr == `ADDR_STATUS);
    wire [7:0] asg_off    = reg_addr - `ADDR_ASSIGN_BASE;
    wire [5:0] asg_idx    = asg_off[7:2];
    wire       hit_assign = (reg_addr >= `ADDR_ASSIGN_BASE)
                         && (asg_off[1:0] == 2'h0)
                         && (asg_idx < 6'(TERM_COUNT));
    wire       cfg_wr     = reg_wr && hit_cfg;

    // source settings are locked while running unless run-write is allowed
    wire src_wr_ok = !drive_running || (pws_q == `PWS_RUN_WRITE); // [RQ6]

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            src_req_q.operation_cmd_source_sel <= `RST_OP_SRC;
            src_req_q.speed_cmd_source_sel     <= `RST_SPD_SRC;
        end else if (cfg_wr && src_wr_ok) begin
            src_req_q.operation_cmd_source_sel <= reg_wdata[`CFG_OP_BIT];
            src_req_q.speed_cmd_source_sel <=
                reg_wdata[`CFG_SPD_LSB +: 2];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pws_q      <= `RST_PWS;
            seq_sel_q  <= `RST_SEQ;
            net_mode_q <= `RST_NETMODE;
        end else if (cfg_wr) begin
            pws_q      <= reg_wdata[`CFG_PWS_LSB +: 2];
            seq_sel_q  <= reg_wdata[`CFG_SEQ_LSB +: 2];
            net_mode_q <= reg_wdata[`CFG_NETMODE_BIT];
        end
    end

    // terminal function assignment and switchover level
    logic [TERM_COUNT-1:0] sw_match;

    generate
        for (genvar i = 0; i < TERM_COUNT; i++) begin : g_term
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    assign_q[i] <= `RST_ASSIGN;
                end else if (reg_wr && hit_assign
                             && asg_idx == 6'(i)) begin
                    assign_q[i] <= reg_wdata[7:0];
                end
            end
            assign sw_match[i] = (assign_q[i] == `SWITCHOVER_CODE); // [RQ8]
        end
    endgenerate

    // several terminals carrying the function act as one wired-or input
    wire sw_assigned = |sw_match; // [RQ8]
    wire sw_live     = |(sw_match & pins_s);

    // settings and switchover move only while the drive is stopped
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            src_act_q.operation_cmd_source_sel <= `RST_OP_SRC;
            src_act_q.speed_cmd_source_sel     <= `RST_SPD_SRC;
            sw_act_q                           <= 1'h0;
        end else if (!drive_running) begin
            src_act_q <= src_req_q; // [RQ7]
            sw_act_q  <= sw_live;   // [RQ11]
        end
    end

    // source selection
    wire sw_allows = !sw_assigned || sw_act_q; // [RQ9]
    wire op_net_d  = net_mode_q && sw_allows
                  && (src_act_q.operation_cmd_source_sel == `SRC_NET); // [RQ1]
    wire spd_net_d = net_mode_q && sw_allows
                  && (src_act_q.speed_cmd_source_sel == `SPD_NET); // [RQ9]
    // a switchover that reads off forces terminals for both commands
    wire sw_off    = sw_assigned && !sw_act_q; // [RQ10]

    // merging
    func_bits_type eff_d;
    func_bits_type routed;

    assign routed = op_net_d ? n_s : t_s; // [RQ1]

    assign eff_d.control_mode_switch = routed.control_mode_switch;
    assign eff_d.torque_limit_sel    = routed.torque_limit_sel;
    assign eff_d.torque_bias_sel1    = routed.torque_bias_sel1;
    assign eff_d.torque_bias_sel2    = routed.torque_bias_sel2;
    assign eff_d.pulse_monitor_clear = routed.pulse_monitor_clear;
    assign eff_d.flux_decay_shutoff  = routed.flux_decay_shutoff;
    assign eff_d.forward_run_cmd     = routed.forward_run_cmd;
    assign eff_d.reverse_run_cmd     = routed.reverse_run_cmd;
    // normally-open merge, independent of every source setting
    assign eff_d.emergency_drive_cmd =
        t_s.emergency_drive_cmd | n_s.emergency_drive_cmd; // [RQ2] [RQ4]
    // normally-closed merge in network mode: an open contact on either side wins; otherwise the terminal alone decides
    assign eff_d.sudden_stop_in = net_mode_q
        ? (t_s.sudden_stop_in & n_s.sudden_stop_in)
        : t_s.sudden_stop_in; // [RQ5]
    assign eff_d.forward_stroke_end = net_mode_q
        ? (t_s.forward_stroke_end & n_s.forward_stroke_end)
        : t_s.forward_stroke_end; // [RQ5]
    assign eff_d.reverse_stroke_end = net_mode_q
        ? (t_s.reverse_stroke_end & n_s.reverse_stroke_end)
        : t_s.reverse_stroke_end; // [RQ5]
    assign eff_d.sequence_start_in = (seq_sel_q == `SEQ_EITHER)
        ? (t_s.sequence_start_in | n_s.sequence_start_in)
        : t_s.sequence_start_in; // [RQ3] [RQ4]

    // network reset gate
    wire net_rst_edge = net_rst_s && !net_rst_prev_q;
    wire reset_d      = net_rst_edge && !sw_off; // [RQ12]

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            eff_q          <= '0;
            op_net_q       <= 1'h0;
            spd_net_q      <= 1'h0;
            speed_q        <= '0;
            net_rst_prev_q <= 1'h0;
            reset_req_q    <= 1'h0;
        end else begin
            eff_q          <= eff_d;
            op_net_q       <= op_net_d;
            spd_net_q      <= spd_net_d;
            speed_q        <= spd_net_d ? net_speed : term_speed;
            net_rst_prev_q <= net_rst_s;
            reset_req_q    <= reset_d;
        end
    end

    assign eff_func        = eff_q;
    assign op_from_net     = op_net_q;
    assign spd_from_net    = spd_net_q;
    assign speed_ref       = speed_q;
    assign drive_reset_req = reset_req_q;

    // read path
    wire        pending = (src_act_q != src_req_q) || (sw_act_q != sw_live);
    wire [31:0] cfg_word = {23'h0, net_mode_q, seq_sel_q, pws_q,
                            src_req_q.speed_cmd_source_sel, 1'h0,
                            src_req_q.operation_cmd_source_sel};
    wire [31:0] status_word = {3'h0, eff_q, 6'h0, drive_running, pending,
                               spd_net_q, op_net_q, sw_assigned, sw_act_q,
                               src_act_q.speed_cmd_source_sel, 1'h0,
                               src_act_q.operation_cmd_source_sel};
    wire [2:0]  asg_sel  = asg_idx[2:0];
    wire [31:0] asg_word = {24'h0, assign_q[asg_sel]};
    // unmapped addresses read as zero
    wire [31:0] rd_mux = hit_cfg    ? cfg_word
                       : hit_status ? status_word
                       : hit_assign ? asg_word
                       : 32'h0;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 32'h0;
        end
    end

    assign reg_rdata = rdata_q;

    // checks share the one clock and stay quiet while reset is held
    default clocking chk_clk @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence stopped_two;
        !drive_running ##1 !drive_running;
    endsequence

    sequence net_rst_rise;
        net_rst_s && !net_rst_prev_q;
    endsequence

    chk_route_net: assert property ( // [RQ1]
        op_net_d && n_s.forward_run_cmd |=> eff_func.forward_run_cmd)
        else $error("forward run not taken from network");

    chk_emerg_merge: assert property ( // [RQ2]
        1'h1 |=> eff_func.emergency_drive_cmd ==
        ($past(t_s.emergency_drive_cmd) | $past(n_s.emergency_drive_cmd)))
        else $error("emergency drive merge wrong");

    chk_seq_term: assert property ( // [RQ3]
        seq_sel_q == `SEQ_TERM_ONLY && !t_s.sequence_start_in
        |=> !eff_func.sequence_start_in)
        else $error("sequence start accepted from network");

    chk_no_merge: assert property ( // [RQ4]
        seq_sel_q == `SEQ_EITHER && n_s.sequence_start_in
        |=> eff_func.sequence_start_in)
        else $error("normally-open merge lost network input");

    chk_nc_merge: assert property ( // [RQ5]
        net_mode_q && !n_s.sudden_stop_in |=> !eff_func.sudden_stop_in)
        else $error("normally-closed merge ignored open network contact");

    chk_write_guard: assert property ( // [RQ6]
        cfg_wr && drive_running && pws_q != `PWS_RUN_WRITE
        |=> src_req_q == $past(src_req_q))
        else $error("source setting changed while locked");

    chk_hold_run: assert property ( // [RQ7]
        drive_running |=> $stable(src_act_q) && $stable(sw_act_q))
        else $error("source changed while running");

    chk_apply_stop: assert property ( // [RQ11]
        stopped_two |-> src_act_q == $past(src_req_q)
        && sw_act_q == $past(sw_live))
        else $error("setting not applied while stopped");

    chk_term_forced: assert property ( // [RQ10]
        sw_off |=> !op_from_net && !spd_from_net)
        else $error("network source used with switchover off");

    chk_reset_gate: assert property ( // [RQ12]
        net_rst_rise |=> drive_reset_req == !$past(sw_off))
        else $error("network reset gating wrong");

endmodule

//--- src/cmd_src_regs.svh
// register offsets, field positions and reset values of the source arbiter
`ifndef CMD_SRC_REGS_SVH
`define CMD_SRC_REGS_SVH

// byte offsets
`define ADDR_CFG         8'h00
`define ADDR_STATUS      8'h04
`define ADDR_ASSIGN_BASE 8'h10
`define ASSIGN_COUNT     7

// configuration register fields
`define CFG_OP_BIT       0
`define CFG_SPD_LSB      2
`define CFG_PWS_LSB      4
`define CFG_SEQ_LSB      6
`define CFG_NETMODE_BIT  8

// status register fields
`define ST_OP_ACT_BIT    0
`define ST_SPD_ACT_LSB   2
`define ST_SW_ACT_BIT    4
`define ST_SW_ASGN_BIT   5
`define ST_OP_NET_BIT    6
`define ST_SPD_NET_BIT   7
`define ST_PENDING_BIT   8
`define ST_RUNNING_BIT   9
`define ST_FUNC_LSB      16

// reset values
`define RST_OP_SRC       1'h0
`define RST_SPD_SRC      2'h0
`define RST_PWS          2'h0
`define RST_SEQ          2'h2
`define RST_NETMODE      1'h1
`define RST_ASSIGN       8'h00

// setting codes
`define SRC_NET          1'h0
`define SPD_NET          2'h0
`define PWS_RUN_WRITE    2'h2
`define SEQ_EITHER       2'h1
`define SEQ_TERM_ONLY    2'h2
`define SWITCHOVER_CODE  8'h43

`endif

//--- src/cmd_src_pkg.sv
// types shared by the command source arbiter
package cmd_src_pkg;

    // one level per drive input function, routed or merged
    typedef struct packed {
        logic control_mode_switch;
        logic torque_limit_sel;
        logic torque_bias_sel1;
        logic torque_bias_sel2;
        logic pulse_monitor_clear;
        logic flux_decay_shutoff;
        logic forward_run_cmd;
        logic reverse_run_cmd;
        logic emergency_drive_cmd;
        logic sudden_stop_in;
        logic forward_stroke_end;
        logic reverse_stroke_end;
        logic sequence_start_in;
    } func_bits_type;

    // settings that take effect only while stopped
    typedef struct packed {
        logic       operation_cmd_source_sel;
        logic [1:0] speed_cmd_source_sel;
    } src_sel_type;

endpackage

//--- src/sync_bank.sv
// bank of two-stage synchronisers for asynchronous input levels
`timescale 1ns/100ps
module sync_bank #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

//--- tb/drive_io_model.sv
// far-side model: terminal wiring and network master
`timescale 1ns/100ps
module drive_io_model
    import cmd_src_pkg::*;
(
    // clock
    input  wire logic ref_clk,
    // terminal side
    output func_bits_type term_func,
    output logic [6:0]    term_pins,
    output logic [15:0]   term_speed,
    // network side
    output func_bits_type net_func,
    output logic          net_reset_req,
    output logic [15:0]   net_speed
);
    initial begin
        term_func = '0;
        net_func = '0;
        term_pins = 7'h00;
        net_reset_req = 1'h0;
        term_speed = 16'hA5C3;
        net_speed = 16'h1234;
    end
    task automatic apply(input func_bits_type t, input func_bits_type n,
                         input logic [6:0] p);
        @(posedge ref_clk);
        term_func <= t;
        net_func <= n;
        term_pins <= p;
    endtask
    // held past the synchroniser, then dropped so each request is an edge
    task automatic send_reset();
        @(posedge ref_clk);
        net_reset_req <= 1'h1;
        repeat (3) @(posedge ref_clk);
        net_reset_req <= 1'h0;
    endtask
endmodule

//--- tb/command_source_arbiter_test.sv
// self-checking bench for the command source arbiter
`timescale 1ns/100ps
module command_source_arbiter_test
    import cmd_src_pkg::*;
;
    logic ref_clk, sys_rst, reg_wr, reg_rd, drive_running, seen;
    logic net_reset_req, op_from_net, spd_from_net, drive_reset_req;
    logic [7:0]    reg_addr;
    logic [31:0]   reg_wdata, reg_rdata, rdata;
    logic [6:0]    term_pins;
    logic [15:0]   term_speed, net_speed, speed_ref;
    func_bits_type term_func, net_func, eff_func, t_v, n_v;
    logic [12:0]   exp_v;
    int            n_errors, tests_run;
    // functions that follow the operation source
    localparam logic [12:0] ROUTED = 13'h1FE0;

    command_source_arbiter command_source_arbiter_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .drive_running(drive_running),
        .term_func(term_func), .term_pins(term_pins),
        .term_speed(term_speed), .net_func(net_func),
        .net_reset_req(net_reset_req), .net_speed(net_speed),
        .eff_func(eff_func), .op_from_net(op_from_net),
        .spd_from_net(spd_from_net), .speed_ref(speed_ref),
        .drive_reset_req(drive_reset_req));
    drive_io_model drive_io_model_inst (
        .ref_clk(ref_clk), .term_func(term_func), .term_pins(term_pins),
        .term_speed(term_speed), .net_func(net_func),
        .net_reset_req(net_reset_req), .net_speed(net_speed));

    initial begin
        ref_clk = 1'h0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1;
        rdata = reg_rdata;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (6) @(posedge ref_clk);
        #1;
    endtask
    // fixed window: the pulse is due three edges after the request rises
    task automatic try_reset();
        seen = 1'h0;
        fork
            drive_io_model_inst.send_reset();
            repeat (12) begin
                @(posedge ref_clk);
                #1;
                if (drive_reset_req === 1'h1) seen = 1'h1;
            end
        join
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        summarize();
    end

    initial begin
        sys_rst = 1'h1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        drive_running = 1'h0;
        n_errors = 0;
        tests_run = 0;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'h0;
        rd(8'h00);
        check(rdata, 32'h0000_0180);
        rd(8'h08);
        check(rdata, 32'h0);
        check(op_from_net, 1'h1);
        check(spd_from_net, 1'h1);
        for (int o = 0; o < 2; o++) begin
            wr(8'h00, 32'h0000_0180 | o);
            drive_io_model_inst.apply('0, ROUTED, 7'h00);
            @(posedge ref_clk);
            #1;
            if (o == 0) check(eff_func & ROUTED, 13'h0);
            settle();
            check(eff_func & ROUTED, o ? 13'h0 : ROUTED);
            check(op_from_net, o ? 1'h0 : 1'h1);
            for (int i = 0; i < 4; i++) begin
                t_v = '0;
                n_v = '0;
                {t_v.emergency_drive_cmd, t_v.sudden_stop_in} = {2{i[1]}};
                {t_v.forward_stroke_end, t_v.reverse_stroke_end} = {2{i[1]}};
                {n_v.emergency_drive_cmd, n_v.sudden_stop_in} = {2{i[0]}};
                {n_v.forward_stroke_end, n_v.reverse_stroke_end} = {2{i[0]}};
                drive_io_model_inst.apply(t_v, n_v, 7'h00);
                settle();
                check(eff_func.emergency_drive_cmd, i[1] | i[0]);
                exp_v = {13{i[1] & i[0]}} & 13'h000E;
                if (o == 0) check(eff_func & 13'h000E, exp_v);
            end
        end
        wr(8'h00, 32'h0000_0180);
        n_v = '0;
        n_v.sequence_start_in = 1'h1;
        drive_io_model_inst.apply('0, n_v, 7'h00);
        settle();
        check(eff_func.sequence_start_in, 1'h0);
        wr(8'h00, 32'h0000_0140);
        settle();
        check(eff_func.sequence_start_in, 1'h1);
        drive_io_model_inst.apply(n_v, '0, 7'h00);
        settle();
        check(eff_func.sequence_start_in, 1'h1);
        wr(8'h00, 32'h0000_0180);
        drive_io_model_inst.apply('0, ROUTED, 7'h00);
        @(posedge ref_clk);
        drive_running <= 1'h1;
        wr(8'h00, 32'h0000_0181);
        rd(8'h00);
        check(rdata, 32'h0000_0180);
        wr(8'h00, 32'h0000_01A0);
        wr(8'h00, 32'h0000_01A1);
        rd(8'h00);
        check(rdata, 32'h0000_01A1);
        settle();
        check(op_from_net, 1'h1);
        check(eff_func & ROUTED, ROUTED);
        @(posedge ref_clk);
        drive_running <= 1'h0;
        settle();
        check(op_from_net, 1'h0);
        check(eff_func & ROUTED, 13'h0);
        wr(8'h00, 32'h0000_0180);
        drive_io_model_inst.apply('0, '0, 7'h08);
        wr(8'h1C, 32'h0000_0043);
        rd(8'h1C);
        check(rdata, 32'h0000_0043);
        rd(8'h04);
        check(rdata[5], 1'h1);
        settle();
        check(op_from_net, 1'h1);
        check(spd_from_net, 1'h1);
        check(speed_ref, 16'h1234);
        try_reset();
        check(seen, 1'h1);
        drive_io_model_inst.apply('0, '0, 7'h00);
        settle();
        check(op_from_net, 1'h0);
        check(spd_from_net, 1'h0);
        check(speed_ref, 16'hA5C3);
        try_reset();
        check(seen, 1'h0);
        @(posedge ref_clk);
        drive_running <= 1'h1;
        drive_io_model_inst.apply('0, '0, 7'h08);
        settle();
        check(op_from_net, 1'h0);
        @(posedge ref_clk);
        drive_running <= 1'h0;
        settle();
        check(op_from_net, 1'h1);
        summarize();
    end
endmodule
